// >>> rtl/ccs_sequencer.sv
// Purpose: pixel edge delays, line pulse decode, per-pixel gain select
// Assumes: pins come from the sensor timing generator, unsynchronised;
//          configuration words are static register outputs on i_ref_clk
// Notes:   delay steps round up to whole 4 ns cycles
// Functional notes
// [RQ1] delays act on polarity-corrected pixel clocks
// [RQ2] black delay: two 3-bit 1 ns fields
// [RQ3] low field delays black on, high off
// [RQ4] video delay: three 3-bit 1 ns fields
// [RQ5] video low field on, middle off
// [RQ6] phase option: video on after black off
// [RQ7] converter delay: two 4-bit 0.5 ns fields
// [RQ8] converter fields set phase fall, rise
// [RQ9] two-pulse mode: clamp and window separate
// [RQ10] generator never overlaps clamp and window
// [RQ11] single-pulse: first four pixels clamp, rest calibrate
// [RQ12] mode bit one selects single-pulse mode
// [RQ13] preblank disconnects; clamp and window override
// [RQ14] hold option: preblank forces offset onto bus
// [RQ15] gain switches per pixel, two patterns
// [RQ16] enable bit turns on per-pixel gain
// [RQ17] select bit zero picks progressive or interlaced
// [RQ18] source bit zero: parity from parity input
// [RQ19] progressive counter: seed on sync, preblank toggles
// [RQ20] length field gives one to four pixels
// [RQ21] slot pointer picks one of four gains
// [RQ22] preblank latches parity input
// [RQ23] difference subtracted from master gain
// [RQ24] interlaced sync phase gives field parity
// [RQ25] position resets after preblank, wraps at length
`default_nettype none
module ccs_sequencer (
    input  wire logic        i_ref_clk,               // 250 MHz
    input  wire logic        i_rst_n,                 // async, low
    input  wire logic        i_black_sample_strobe,   // pixel pins
    input  wire logic        i_video_sample_strobe,
    input  wire logic        i_converter_clock,
    input  wire logic        i_clamp_pulse,           // line pins
    input  wire logic        i_cal_window_pulse,
    input  wire logic        i_preblank_pulse,
    input  wire logic        i_line_parity_input,
    input  wire logic        i_frame_sync,
    input  wire logic [7:0]  i_pin_polarity,          // 1: active high
    input  wire logic [5:0]  i_black_strobe_delay,
    input  wire logic [8:0]  i_video_strobe_delay,
    input  wire logic [7:0]  i_converter_clock_delay,
    input  wire logic        i_video_phase_option,
    input  wire logic        i_single_pulse_line_mode,
    input  wire logic        i_output_hold_option,
    input  wire logic [7:0]  i_offset_code,
    input  wire logic [11:0] i_conv_data,             // converter result
    input  wire logic        i_per_pixel_gain_enable,
    input  wire logic [1:0]  i_gain_sequencing_select,
    input  wire logic        i_line_counter_seed,
    input  wire logic [9:0]  i_even_line_pattern,
    input  wire logic [9:0]  i_odd_line_pattern,
    input  wire logic [9:0]  i_master_gain,
    input  wire logic [8:0]  i_gain_diff_1,
    input  wire logic [8:0]  i_gain_diff_2,
    input  wire logic [8:0]  i_gain_diff_3,
    output logic             o_black_phase,           // internal switch phases
    output logic             o_video_phase,
    output logic             o_converter_phase,
    output logic             o_clamp_enable,
    output logic             o_calib_window,
    output logic             o_input_disconnect,
    output logic [11:0]      o_output_bus,
    output logic [9:0]       o_gain_code,
    output logic             o_line_pattern_odd
);
    // whole module state
    typedef struct packed {
        logic [ccs_pkg::PIN_N-1:0]  s1;      // first sync stage
        logic [ccs_pkg::PIN_N-1:0]  s2;      // second sync stage
        logic [1:0]                 vld;     // sync stages hold real pin levels
        logic [ccs_pkg::HIST_W-1:0] blk_h;   // edge histories
        logic [ccs_pkg::HIST_W-1:0] vid_h;
        logic [ccs_pkg::HIST_W-1:0] conv_h;
        logic [ccs_pkg::HIST_W-1:0] bfall_h; // black phase low levels
        logic                       blk_ph;
        logic                       vid_ph;
        logic                       conv_ph;
        logic                       preblank_pulse_d;  // previous active levels
        logic                       fs_d;
        logic [2:0]                 cal_px;  // pixels inside window
        logic                       parity;  // 1: odd pattern
        logic [1:0]                 pos;     // pattern position, 0 = first
        logic [9:0]                 gain;
        logic [11:0]                obus;
    } ccs_state_t;

    ccs_state_t q;       // registered state
    ccs_state_t next_q;  // next state

    // delay field to cycle taps, rounded up
    function automatic logic [1:0] taps(input logic [3:0] v, input int step);
        int t;
        t = (int'(v) * step + ccs_pkg::CLK_PERIOD_PS - 1) / ccs_pkg::CLK_PERIOD_PS;
        return 2'(t);
    endfunction

    // slot pointer to gain code
    function automatic logic [9:0] gain_of(input logic [1:0] slot,
                                           input logic [9:0] m,
                                           input logic [8:0] d1,
                                           input logic [8:0] d2,
                                           input logic [8:0] d3);
        logic [9:0] g;
        case (slot)
            2'h0:    g = m;
            2'h1:    g = m - {1'b0, d1};  // [RQ23]
            2'h2:    g = m - {1'b0, d2};  // [RQ23]
            default: g = m - {1'b0, d3};  // [RQ23]
        endcase
        return g;
    endfunction

    logic [ccs_pkg::PIN_N-1:0] act;    // polarity-corrected pins
    logic [1:0] t_bl, t_bt, t_vl, t_vt, t_vp, t_cl, t_ct;
    logic       blk_on, blk_off, vid_on, vid_off, conv_on, conv_off;
    logic       px_tick, preblank_pulse_rise, preblank_pulse_fall, fs_rise;
    logic [9:0] pat;                   // active line pattern
    logic [1:0] last_pos;
    logic [1:0] slot;

    // polarity first, then delays; inactive until sync stages filled, no false edge
    assign act = q.vld[1] ? ~(q.s2 ^ i_pin_polarity) : '0;  // [RQ1]

    // field extraction into taps
    assign t_bl = taps({1'b0, i_black_strobe_delay[ccs_pkg::BLK_LEAD_LSB +: ccs_pkg::DLY3_W]},
                       ccs_pkg::SAMPLE_STEP_PS);  // [RQ2]
    assign t_bt = taps({1'b0, i_black_strobe_delay[ccs_pkg::BLK_TRAIL_LSB +: ccs_pkg::DLY3_W]},
                       ccs_pkg::SAMPLE_STEP_PS);  // [RQ2]
    assign t_vl = taps({1'b0, i_video_strobe_delay[ccs_pkg::VID_LEAD_LSB +: ccs_pkg::DLY3_W]},
                       ccs_pkg::SAMPLE_STEP_PS);  // [RQ4]
    assign t_vt = taps({1'b0, i_video_strobe_delay[ccs_pkg::VID_TRAIL_LSB +: ccs_pkg::DLY3_W]},
                       ccs_pkg::SAMPLE_STEP_PS);  // [RQ4]
    assign t_vp = taps({1'b0, i_video_strobe_delay[ccs_pkg::VID_PHASE_LSB +: ccs_pkg::DLY3_W]},
                       ccs_pkg::SAMPLE_STEP_PS);  // [RQ4]
    assign t_cl = taps(i_converter_clock_delay[ccs_pkg::CONV_LEAD_LSB +: ccs_pkg::DLY4_W],
                       ccs_pkg::CONV_STEP_PS);    // [RQ7]
    assign t_ct = taps(i_converter_clock_delay[ccs_pkg::CONV_TRAIL_LSB +: ccs_pkg::DLY4_W],
                       ccs_pkg::CONV_STEP_PS);    // [RQ7]

    // delayed edges: leading sets a phase, trailing clears it, no glitch between
    assign blk_on   = q.blk_h[t_bl] & ~q.blk_h[t_bl + 2'h1];      // [RQ3]
    assign blk_off  = ~q.blk_h[t_bt] & q.blk_h[t_bt + 2'h1];      // [RQ3]
    assign vid_on   = i_video_phase_option ? q.bfall_h[t_vp] & q.vid_h[t_vt]   // [RQ6]
                                           : q.vid_h[t_vl] & ~q.vid_h[t_vl + 2'h1];  // [RQ5]
    assign vid_off  = ~q.vid_h[t_vt] & q.vid_h[t_vt + 2'h1];      // [RQ5]
    assign conv_on  = q.conv_h[t_cl] & ~q.conv_h[t_cl + 2'h1];    // [RQ8]
    assign conv_off = ~q.conv_h[t_ct] & q.conv_h[t_ct + 2'h1];    // [RQ8]

    // line and pixel events
    assign px_tick   = ~q.blk_ph & blk_on;
    assign preblank_pulse_rise = act[ccs_pkg::PIN_PREBLANK_PULSE] & ~q.preblank_pulse_d;
    assign preblank_pulse_fall = ~act[ccs_pkg::PIN_PREBLANK_PULSE] & q.preblank_pulse_d;
    assign fs_rise   = act[ccs_pkg::PIN_FSYNC] & ~q.fs_d;

    // pattern choice and current slot
    assign pat      = q.parity ? i_odd_line_pattern : i_even_line_pattern;
    assign last_pos = pat[ccs_pkg::PAT_LEN_LSB +: 2];                 // [RQ20]
    assign slot     = pat[ccs_pkg::PAT_SLOT_LSB + 2 * q.pos +: 2];    // [RQ21]

    // next state
    always_comb
    begin
        next_q    = q;
        next_q.s1 = {i_frame_sync, i_line_parity_input, i_preblank_pulse,
                     i_cal_window_pulse, i_clamp_pulse, i_converter_clock,
                     i_video_sample_strobe, i_black_sample_strobe};
        next_q.s2 = q.s1;
        // shift edge histories
        next_q.blk_h  = {q.blk_h[ccs_pkg::HIST_W-2:0], act[ccs_pkg::PIN_BLK]};
        next_q.vid_h  = {q.vid_h[ccs_pkg::HIST_W-2:0], act[ccs_pkg::PIN_VID]};
        next_q.conv_h = {q.conv_h[ccs_pkg::HIST_W-2:0], act[ccs_pkg::PIN_CONV]};
        // sync stages fill after reset
        next_q.vld     = {q.vld[0], 1'b1};
        // phases: on by leading edge view, off by trailing edge view
        next_q.blk_ph  = q.blk_ph ? ~blk_off : blk_on;      // [RQ3]
        // black phase low level, delayed for the video option
        next_q.bfall_h = {q.bfall_h[ccs_pkg::HIST_W-2:0], ~next_q.blk_ph};
        next_q.vid_ph  = q.vid_ph ? ~vid_off : vid_on;      // [RQ5] [RQ6]
        next_q.conv_ph = q.conv_ph ? ~conv_off : conv_on;   // [RQ8]
        next_q.preblank_pulse_d = act[ccs_pkg::PIN_PREBLANK_PULSE];
        next_q.fs_d   = act[ccs_pkg::PIN_FSYNC];
        // pixel count within window pulse, saturating
        if (!act[ccs_pkg::PIN_CAL])
        begin
            next_q.cal_px = 3'h0;
        end
        else if (px_tick && q.cal_px < ccs_pkg::CLAMP_PIXELS)
        begin
            next_q.cal_px = q.cal_px + 3'h1;  // [RQ11]
        end
        // line parity source
        if (!i_gain_sequencing_select[ccs_pkg::GSEL_SRC])
        begin
            if (preblank_pulse_rise)
            begin
                next_q.parity = act[ccs_pkg::PIN_EOS];  // [RQ18] [RQ22]
            end
        end
        else if (i_gain_sequencing_select[ccs_pkg::GSEL_SCAN])
        begin
            if (fs_rise)
            begin
                next_q.parity = i_line_counter_seed;    // [RQ17] [RQ19]
            end
            else if (preblank_pulse_rise)
            begin
                next_q.parity = ~q.parity;              // [RQ19]
            end
        end
        else if (fs_rise)
        begin
            next_q.parity = act[ccs_pkg::PIN_EOS];      // [RQ17] [RQ24]
        end
        // pattern position
        if (preblank_pulse_fall)
        begin
            next_q.pos = 2'h0;                          // [RQ25]
        end
        else if (px_tick && !act[ccs_pkg::PIN_PREBLANK_PULSE])
        begin
            next_q.pos = (q.pos >= last_pos) ? 2'h0 : q.pos + 2'h1;  // [RQ20] [RQ25]
        end
        // gain for current pixel
        if (i_per_pixel_gain_enable)
        begin
            next_q.gain = gain_of(slot, i_master_gain, i_gain_diff_1,
                                  i_gain_diff_2, i_gain_diff_3);  // [RQ15] [RQ16]
        end
        else
        begin
            next_q.gain = i_master_gain;
        end
        // output bus, offset forced while blanking
        if (i_output_hold_option && act[ccs_pkg::PIN_PREBLANK_PULSE])
        begin
            next_q.obus = {4'h0, i_offset_code};        // [RQ14]
        end
        else
        begin
            next_q.obus = i_conv_data;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // line pulse decode, both modes
    always_comb
    begin
        if (i_single_pulse_line_mode)
        begin
            o_clamp_enable = act[ccs_pkg::PIN_CAL] & (q.cal_px < ccs_pkg::CLAMP_PIXELS);  // [RQ11] [RQ12]
            o_calib_window = act[ccs_pkg::PIN_CAL] & (q.cal_px >= ccs_pkg::CLAMP_PIXELS); // [RQ11]
        end
        else
        begin
            o_clamp_enable = act[ccs_pkg::PIN_CLAMP];  // [RQ9] [RQ10]
            o_calib_window = act[ccs_pkg::PIN_CAL];    // [RQ9]
        end
        // clamp and window override blanking
        o_input_disconnect = act[ccs_pkg::PIN_PREBLANK_PULSE] & ~o_clamp_enable & ~o_calib_window;  // [RQ13]
    end

    // registered outputs
    assign o_black_phase      = q.blk_ph;
    assign o_video_phase      = q.vid_ph;
    assign o_converter_phase  = ~q.conv_ph;  // [RQ8] falls on leading, rises on trailing
    assign o_output_bus       = q.obus;
    assign o_gain_code        = q.gain;
    assign o_line_pattern_odd = q.parity;

    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_hold_req;
        i_output_hold_option && act[ccs_pkg::PIN_PREBLANK_PULSE];
    endsequence

    sequence s_line_end;
        q.preblank_pulse_d && !act[ccs_pkg::PIN_PREBLANK_PULSE];
    endsequence

    AST_BLK_ON: assert property ($rose(o_black_phase) |-> $past(blk_on))  // [RQ3]
        else $error("black phase rose without delayed leading edge");
    AST_BLK_OFF: assert property ($fell(o_black_phase) |-> $past(blk_off))  // [RQ3]
        else $error("black phase fell without delayed trailing edge");
    AST_VID_ON: assert property (!i_video_phase_option && $rose(o_video_phase)
        |-> $past(q.vid_h[t_vl]))  // [RQ5]
        else $error("video phase rose without delayed leading edge");
    AST_VID_OPT: assert property (i_video_phase_option && $rose(o_video_phase)
        |-> $past(q.bfall_h[t_vp]))  // [RQ6]
        else $error("video phase rose before black phase delay");
    AST_CONV_ON: assert property ($fell(o_converter_phase) |-> $past(conv_on))  // [RQ8]
        else $error("converter phase fell without delayed leading edge");
    AST_CLAMP_SPM: assert property (i_single_pulse_line_mode && o_clamp_enable
        |-> act[ccs_pkg::PIN_CAL] && q.cal_px < 3'h4 && !o_calib_window)  // [RQ11]
        else $error("single pulse clamp outside first pixels");
    AST_DISC: assert property (o_input_disconnect |-> !o_clamp_enable && !o_calib_window)  // [RQ13]
        else $error("blanking overrode clamp or window");
    AST_HOLD: assert property (s_hold_req |=> o_output_bus == {4'h0, $past(i_offset_code)})  // [RQ14]
        else $error("offset not forced on output bus");
    AST_POS: assert property (s_line_end |=> q.pos == 2'h0)  // [RQ25]
        else $error("pattern position not reset at line start");
    AST_PAR_TOG: assert property (i_gain_sequencing_select == 2'h3 && !fs_rise && preblank_pulse_rise
        |=> o_line_pattern_odd != $past(o_line_pattern_odd))  // [RQ19]
        else $error("parity counter did not toggle");
    AST_GAIN_OFF: assert property (!i_per_pixel_gain_enable |=> o_gain_code == $past(i_master_gain))  // [RQ16]
        else $error("gain not master while sequencing off");
endmodule
`default_nettype wire

// >>> shared/ccs_pkg.sv
// Purpose: constants for the pixel/line timing and gain sequencer
// Assumes: one 250 MHz clock; delays realised in whole clock cycles
// Notes:   field positions of the delay and line pattern words
`default_nettype none
package ccs_pkg;
    // clock rate and derived period
    localparam int CLK_FREQ_MHZ  = 250;
    localparam int CLK_PERIOD_PS = 1000000 / CLK_FREQ_MHZ;
    // delay step sizes in picoseconds
    localparam int SAMPLE_STEP_PS = 1000;
    localparam int CONV_STEP_PS   = 500;
    // edge history depth, covers the largest tap
    localparam int HIST_W = 4;
    // pin order inside the sampled vector and polarity word
    localparam int PIN_BLK   = 0;
    localparam int PIN_VID   = 1;
    localparam int PIN_CONV  = 2;
    localparam int PIN_CLAMP = 3;
    localparam int PIN_CAL   = 4;
    localparam int PIN_PREBLANK_PULSE  = 5;
    localparam int PIN_EOS   = 6;
    localparam int PIN_FSYNC = 7;
    localparam int PIN_N     = 8;
    // delay field layout
    localparam int DLY3_W         = 3;
    localparam int DLY4_W         = 4;
    localparam int BLK_LEAD_LSB   = 0;
    localparam int BLK_TRAIL_LSB  = 3;
    localparam int VID_LEAD_LSB   = 0;
    localparam int VID_TRAIL_LSB  = 3;
    localparam int VID_PHASE_LSB  = 6;
    localparam int CONV_LEAD_LSB  = 0;
    localparam int CONV_TRAIL_LSB = 4;
    // line pattern layout: length then four 2-bit slot pointers
    localparam int PAT_LEN_LSB  = 0;
    localparam int PAT_SLOT_LSB = 2;
    // gain sequencing select bits
    localparam int GSEL_SCAN = 0;
    localparam int GSEL_SRC  = 1;
    // clamp pixels at the head of a window pulse in single-pulse mode
    localparam logic [2:0] CLAMP_PIXELS = 3'h4;
endpackage
`default_nettype wire

// >>> tb/ccs_tgen.sv
// Purpose: behavioural sensor timing generator driving the sequencer pins
// Assumes: pins change just after a rising edge of the reference clock
// Notes:   requests are made in active terms; polarity maps them to levels
`default_nettype none
module ccs_tgen (
    input  wire logic       i_ref_clk,      // reference clock
    input  wire logic [7:0] i_pin_polarity, // 1: pin active high
    output logic      [7:0] o_pins          // pin levels
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] act = 8'h00; // active state of each pin
    // level follows polarity; parity active means an odd line
    assign o_pins = ~(act ^ i_pin_polarity);
    // move one pin after an edge; clamp and window never overlap
    task automatic set(input int idx, input logic a);
        @(posedge i_ref_clk);
        act[idx] <= a;
        if (a && idx == ccs_pkg::PIN_CLAMP)
            act[ccs_pkg::PIN_CAL] <= 1'b0;
        if (a && idx == ccs_pkg::PIN_CAL)
            act[ccs_pkg::PIN_CLAMP] <= 1'b0;
    endtask
    // active pulse of w cycles
    task automatic pulse(input int idx, input int w);
        set(idx, 1'b1);
        repeat (w - 1) @(posedge i_ref_clk);
        set(idx, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_ccs_sequencer.sv
// Purpose: self-checking bench for the pixel/line timing and gain sequencer
// Assumes: 250 MHz clock; pins come from the timing generator model
// Notes:   edge latencies are judged against one common pipeline offset
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_ccs_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;             // reference clock
    logic        rst_n = 1'b0;           // async reset, low
    logic [7:0]  pol = 8'h40;            // pin polarity, parity active high
    logic [7:0]  pins;                   // pin levels from the generator
    logic [5:0]  bdly = 6'h00;           // black edge delays
    logic [8:0]  vdly = 9'h000;          // video edge delays
    logic [7:0]  cdly = 8'h00;           // converter edge delays
    logic        spl = 1'b0, hold = 1'b0, gen = 1'b0, seed = 1'b0, vopt = 1'b0, par;
    logic [1:0]  gsel = 2'h0;            // gain sequencing select
    logic [7:0]  ofs = 8'h00;            // offset code
    logic [11:0] cdat = 12'h000;         // converter result
    logic [9:0]  epat = 10'h005, opat = 10'h005, mg = 10'h000;
    logic [8:0]  d1 = 9'h000, d2 = 9'h000, d3 = 9'h000;
    logic        ph_b, ph_v, ph_c, clmp, calw, disc, odd; // design outputs
    logic [11:0] bus;
    logic [9:0]  gcode;
    int          err_total = 0, n_checks = 0, cyc = 0, base = 0, r;
    ccs_tgen tg (.i_ref_clk(clk), .i_pin_polarity(pol), .o_pins(pins));
    // pin order as in the package
    ccs_sequencer dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_black_sample_strobe(pins[0]),
        .i_video_sample_strobe(pins[1]), .i_converter_clock(pins[2]),
        .i_clamp_pulse(pins[3]), .i_cal_window_pulse(pins[4]), .i_preblank_pulse(pins[5]),
        .i_line_parity_input(pins[6]), .i_frame_sync(pins[7]), .i_pin_polarity(pol),
        .i_black_strobe_delay(bdly), .i_video_strobe_delay(vdly),
        .i_converter_clock_delay(cdly), .i_video_phase_option(vopt),
        .i_single_pulse_line_mode(spl), .i_output_hold_option(hold), .i_offset_code(ofs),
        .i_conv_data(cdat), .i_per_pixel_gain_enable(gen), .i_gain_sequencing_select(gsel),
        .i_line_counter_seed(seed), .i_even_line_pattern(epat), .i_odd_line_pattern(opat),
        .i_master_gain(mg), .i_gain_diff_1(d1), .i_gain_diff_2(d2), .i_gain_diff_3(d3),
        .o_black_phase(ph_b), .o_video_phase(ph_v), .o_converter_phase(ph_c),
        .o_clamp_enable(clmp), .o_calib_window(calw), .o_input_disconnect(disc),
        .o_output_bus(bus), .o_gain_code(gcode), .o_line_pattern_odd(odd));
    // clock, half period 2 ns
    always #2 clk = ~clk;
    // verdict and end of run
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end
    // delay field to whole-cycle tap, rounding up
    function automatic int tap(input int f, input int step);
        return (f * step + ccs_pkg::CLK_PERIOD_PS - 1) / ccs_pkg::CLK_PERIOD_PS;
    endfunction
    // expected gain code at pattern position k
    function automatic logic [9:0] gexp(input logic [9:0] p, input int k);
        logic [1:0] s;
        s = p[2 + 2 * (k % (p[1:0] + 1)) +: 2];
        return s == 2'h0 ? mg : s == 2'h1 ? mg - {1'b0, d1}
             : s == 2'h2 ? mg - {1'b0, d2} : mg - {1'b0, d3};
    endfunction
    // phase output belonging to a pixel pin, converter phase taken inverted
    function automatic logic ph(input int i);
        return i == 0 ? ph_b : i == 1 ? ph_v : ~ph_c;
    endfunction
    // wait n edges, then sample settled outputs
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // count edges from pin edge to phase edge, both directions
    task automatic lat(input int i, input int tl, input int tt);
        int n;
        tg.set(i, 1'b1);
        n = 0;
        do
        begin
            wt(1);
            n++;
        end while (ph(i) !== 1'b1 && n < 20);
        if (base == 0)
            base = n - tl;
        `CHK(n - tl, base)
        wt(14 - n);
        tg.set(i, 1'b0);
        n = 0;
        do
        begin
            wt(1);
            n++;
        end while (ph(i) !== 1'b0 && n < 20);
        `CHK(n - tt, base)
    endtask
    // one pixel: short black strobe then idle
    task automatic pix();
        tg.pulse(ccs_pkg::PIN_BLK, 2);
        wt(8);
    endtask
    // line start: preblank pulse then settle
    task automatic line();
        tg.pulse(ccs_pkg::PIN_PREBLANK_PULSE, 4);
        wt(6);
    endtask
    // clamp, window, disconnect after settling
    task automatic lchk(input logic [2:0] e);
        wt(3);
        `CHK({clmp, calw, disc}, e)
    endtask
    // main sequence
    initial
    begin
        r = $urandom(32'h3C3E7F81);
        wt(4);
        `CHK({ph_b, ph_v, ph_c, bus, gcode, odd}, {3'b001, 23'h0})
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wt(4);
        // pixel delays: corners, then random, both polarities
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            pol[2:0] <= {3{k[2]}};
            bdly <= k[1:0] == 0 ? 6'h00 : k[1:0] == 1 ? 6'h3F : 6'($urandom);
            vdly <= k[1:0] == 0 ? 9'h000 : k[1:0] == 1 ? 9'h1FF : 9'($urandom);
            cdly <= k[1:0] == 0 ? 8'h00 : k[1:0] == 1 ? 8'hFF : 8'($urandom);
            wt(10);
            lat(0, tap(bdly[2:0], ccs_pkg::SAMPLE_STEP_PS), tap(bdly[5:3], ccs_pkg::SAMPLE_STEP_PS));
            lat(1, tap(vdly[2:0], ccs_pkg::SAMPLE_STEP_PS), tap(vdly[5:3], ccs_pkg::SAMPLE_STEP_PS));
            lat(2, tap(cdly[3:0], ccs_pkg::CONV_STEP_PS), tap(cdly[7:4], ccs_pkg::CONV_STEP_PS));
        end
        `CHK(base == 3 || base == 4, 1'b1)
        // video option: video on after black off plus both delays
        for (int k = 0; k < 3; k++)
        begin
            int ve;
            @(posedge clk);
            vopt <= 1'b1;
            bdly <= 6'($urandom);
            vdly <= 9'($urandom);
            tg.set(ccs_pkg::PIN_BLK, 1'b1);
            wt(8);
            tg.set(ccs_pkg::PIN_VID, 1'b1);
            wt(8);
            `CHK(ph_v, 1'b0)
            tg.set(ccs_pkg::PIN_BLK, 1'b0);
            r = 0;
            do
            begin
                wt(1);
                r++;
            end while (ph_v !== 1'b1 && r < 20);
            ve = base + tap(bdly[5:3], ccs_pkg::SAMPLE_STEP_PS) + 1;
            ve += tap(vdly[8:6], ccs_pkg::SAMPLE_STEP_PS);
            `CHK(r, ve)
            tg.set(ccs_pkg::PIN_VID, 1'b0);
            wt(8);
        end
        @(posedge clk);
        vopt <= 1'b0;
        $display("test delays done");
        // two-pulse line mode, preblank overlap
        @(posedge clk);
        bdly <= 6'h00;
        pol <= (8'($urandom) & 8'hB8) | 8'h40;
        wt(10);
        tg.set(ccs_pkg::PIN_CLAMP, 1'b1);
        lchk(3'b100);
        tg.set(ccs_pkg::PIN_PREBLANK_PULSE, 1'b1);
        lchk(3'b100);
        tg.set(ccs_pkg::PIN_CLAMP, 1'b0);
        lchk(3'b001);
        tg.set(ccs_pkg::PIN_CAL, 1'b1);
        lchk(3'b010);
        tg.set(ccs_pkg::PIN_CAL, 1'b0);
        tg.set(ccs_pkg::PIN_PREBLANK_PULSE, 1'b0);
        lchk(3'b000);
        // single-pulse mode: four clamp pixels, then calibration
        @(posedge clk);
        spl <= 1'b1;
        tg.set(ccs_pkg::PIN_CAL, 1'b1);
        lchk(3'b100);
        repeat (3) pix();
        lchk(3'b100);
        pix();
        lchk(3'b010);
        tg.set(ccs_pkg::PIN_CAL, 1'b0);
        lchk(3'b000);
        @(posedge clk);
        spl <= 1'b0;
        $display("test line modes done");
        // output hold under preblank
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            hold <= 1'b1;
            ofs <= 8'($urandom);
            cdat <= 12'($urandom);
            tg.set(ccs_pkg::PIN_PREBLANK_PULSE, 1'b1);
            wt(4);
            `CHK(bus, {4'h0, ofs})
            @(posedge clk);
            hold <= 1'b0;
            wt(3);
            `CHK(bus, cdat)
            tg.set(ccs_pkg::PIN_PREBLANK_PULSE, 1'b0);
            @(posedge clk);
            hold <= 1'b1;
            wt(4);
            `CHK(bus, cdat)
        end
        $display("test output hold done");
        // per-pixel gain, parity from the parity pin, every length
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            gen <= 1'b1;
            gsel <= {1'b0, k[2]};
            epat <= {8'($urandom), 2'(k)};
            opat <= {8'($urandom), ~2'(k)};
            mg <= 10'($urandom);
            d1 <= 9'($urandom);
            d2 <= 9'($urandom);
            d3 <= 9'($urandom);
            par = 1'($urandom);
            tg.set(ccs_pkg::PIN_EOS, par);
            line();
            `CHK(odd, par)
            for (int j = 0; j < 6; j++)
            begin
                `CHK(gcode, gexp(par ? opat : epat, j))
                pix();
            end
        end
        @(posedge clk);
        gen <= 1'b0;
        wt(3);
        `CHK(gcode, mg)
        // progressive, sync derived: seed on frame sync, toggle per line
        @(posedge clk);
        gsel <= 2'h3;
        seed <= 1'($urandom);
        tg.pulse(ccs_pkg::PIN_FSYNC, 2);
        wt(6);
        par = seed;
        for (int k = 0; k < 4; k++)
        begin
            `CHK(odd, par)
            line();
            par = ~par;
        end
        // interlaced, sync derived: parity pin level at frame start
        @(posedge clk);
        gsel <= 2'h2;
        for (int k = 0; k < 3; k++)
        begin
            par = 1'($urandom);
            tg.set(ccs_pkg::PIN_EOS, par);
            wt(3);
            tg.pulse(ccs_pkg::PIN_FSYNC, 2);
            wt(6);
            `CHK(odd, par)
        end
        $display("test gain sequencing done");
        end_of_test();
    end
endmodule
`default_nettype wire
